// ==== rtl/cmd_serial_defines.vh ====
// Constants for the command serial receiver: rates, frame and buffer sizes.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef CMD_SERIAL_DEFINES_VH
`define CMD_SERIAL_DEFINES_VH
`define CLK_HZ 100000000
`define BAUD_0 9600
`define BAUD_1 19200
`define BAUD_2 38400
`define BAUD_3 115200
// Cycles per bit at CLK_HZ, rounded down, sized to the bit counter.
// Sized literals keep a 32-bit quotient out of the 14-bit registers.
`define BIT_CYC_0 14'h28B0
`define BIT_CYC_1 14'h1458
`define BIT_CYC_2 14'h0A2C
`define BIT_CYC_3 14'h0364
`define DATA_BITS 8
`define BUF_DEPTH 512
`define PTR_W 9
`define CNT_W 14
// Stop accepting when this many bytes or fewer remain free.
`define RTS_MARGIN 16
`endif

// ==== rtl/rx_ring_mem.v ====
// Receive ring storage: 512 bytes, one write and one registered read port.
// Assumes both ports are on the core clock; addresses are always in range.
`timescale 1ns/1ps
module rx_ring_mem (
  // Clock.
  input wire clk_in,
  // Write port.
  input wire wr_en_in,
  input wire [8:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  // Read port.
  input wire [8:0] rd_addr_in,
  output reg [7:0] rd_data_out
);
  reg [7:0] mem [0:511];

  // Storage has no reset so it can map onto a block memory.
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// ==== rtl/command_serial_receiver_flow.v ====
// Command serial channel: receiver, 512-byte ring buffer, flow control.
// Assumes the consumer pulses rd_take_in to pop one byte; pins are async.
// Function
// - There is one serial channel with receive input, transmit and flow outputs.
// - A character carries eight data bits and one stop bit, no parity.
// - Rate pins select 9600, 19200, 38400 or 115200 bit/s.
// - Both rate pins are pulled up so an open pin reads high.
// - Rate pins are sampled only on leaving reset and ignored afterward.
// - Received bytes go to a circular buffer of 512 bytes.
// - On wrap the writer overwrites unread bytes and never drops input.
// - Flow output is low when data can be taken and high when not.
// - Transmit and flow pins are undriven during reset.
// - While reset is low all operation stops in the reset state.
`timescale 1ns/1ps
`include "cmd_serial_defines.vh"
module command_serial_receiver_flow (
  // Clock and reset.
  input wire clk_in,
  input wire nrst_in,
  // Serial pins.
  input wire rx_in,
  output reg tx_out,
  output reg tx_oe_out,
  output reg rts_n_out,
  output reg rts_n_oe_out,
  // Rate straps, pulled up on the pad.
  input wire rate_pick_hi_in,
  input wire rate_pick_lo_in,
  // Byte consumer side.
  input wire rd_take_in,
  output reg [7:0] rd_data_out,
  output reg rd_valid_out,
  output reg overrun_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  // Bit period for a strap code.
  function [`CNT_W-1:0] bit_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: bit_cycles = `BIT_CYC_0;
        2'b01: bit_cycles = `BIT_CYC_1;
        2'b10: bit_cycles = `BIT_CYC_2;
        default: bit_cycles = `BIT_CYC_3;
      endcase
    end
  endfunction

  reg [1:0] rx_sync_ff;
  reg [1:0] hi_sync_ff;
  reg [1:0] lo_sync_ff;
  reg strap_done_ff;
  reg [1:0] strap_wait_ff;
  reg [`CNT_W-1:0] bit_len_ff;
  reg [1:0] state_ff;
  reg [`CNT_W-1:0] cnt_ff;
  reg [2:0] bit_ff;
  reg [7:0] shift_ff;
  reg [`PTR_W:0] fill_ff;
  reg [`PTR_W-1:0] wr_ptr_ff;
  reg [`PTR_W-1:0] rd_ptr_ff;
  reg rd_pend_ff;
  reg wr_en_ff;
  reg [7:0] wr_byte_ff;
  wire [7:0] mem_q;
  wire rx_s;
  wire take;

  assign rx_s = rx_sync_ff[1];
  assign take = rd_take_in && rd_valid_out;

  // Two-flop synchronisers for the serial line and the straps.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_sync_ff <= 2'b11;
      hi_sync_ff <= 2'b11;
      lo_sync_ff <= 2'b11;
    end else begin
      rx_sync_ff <= {rx_sync_ff[0], rx_in};
      hi_sync_ff <= {hi_sync_ff[0], rate_pick_hi_in};
      lo_sync_ff <= {lo_sync_ff[0], rate_pick_lo_in};
    end
  end

  // Rate is latched once after release; later strap moves are ignored.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_done_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
      bit_len_ff <= `BIT_CYC_3;
    end else if (!strap_done_ff) begin
      // The first two edges only refill the synchronisers; latching then
      // would capture their reset value instead of the strap pins.
      if (strap_wait_ff == 2'h2) begin
        strap_done_ff <= 1'b1;
        bit_len_ff <= bit_cycles({hi_sync_ff[1], lo_sync_ff[1]});
      end else begin
        strap_wait_ff <= strap_wait_ff + 2'h1;
      end
    end
  end

  // Receive state machine; mid-bit sampling, start bit rechecked at half.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff <= {`CNT_W{1'b0}};
      bit_ff <= 3'd0;
      shift_ff <= 8'h00;
      wr_en_ff <= 1'b0;
      wr_byte_ff <= 8'h00;
    end else begin
      wr_en_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (strap_done_ff && !rx_s) begin
            state_ff <= ST_START;
            cnt_ff <= {1'b0, bit_len_ff[`CNT_W-1:1]};
          end
        end
        ST_START: begin
          if (cnt_ff != {`CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (rx_s) begin
            state_ff <= ST_IDLE; // Glitch, not a start bit.
          end else begin
            state_ff <= ST_DATA;
            cnt_ff <= bit_len_ff - 1'b1;
            bit_ff <= 3'd0;
          end
        end
        ST_DATA: begin
          if (cnt_ff != {`CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            shift_ff <= {rx_s, shift_ff[7:1]};
            cnt_ff <= bit_len_ff - 1'b1;
            bit_ff <= bit_ff + 1'b1;
            if (bit_ff == 3'd7) begin
              state_ff <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (cnt_ff != {`CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            // A bad stop bit drops the byte; no parity is checked.
            state_ff <= ST_IDLE;
            wr_en_ff <= rx_s;
            wr_byte_ff <= shift_ff;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  rx_ring_mem rx_ring_mem_i (
    .clk_in(clk_in),
    .wr_en_in(wr_en_ff),
    .wr_addr_in(wr_ptr_ff),
    .wr_data_in(wr_byte_ff),
    .rd_addr_in(rd_ptr_ff),
    .rd_data_out(mem_q)
  );

  // Ring pointers. A full ring keeps writing and drags the reader along,
  // so the oldest unread byte is lost rather than the new one.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_ff <= {`PTR_W{1'b0}};
      rd_ptr_ff <= {`PTR_W{1'b0}};
      fill_ff <= {(`PTR_W+1){1'b0}};
      rd_pend_ff <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
      overrun_out <= 1'b0;
    end else begin
      overrun_out <= 1'b0;
      rd_pend_ff <= 1'b0;
      if (wr_en_ff) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (wr_en_ff && fill_ff == `BUF_DEPTH) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        overrun_out <= 1'b1;
        rd_valid_out <= 1'b0;
        rd_pend_ff <= 1'b0;
      end else if (take) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        fill_ff <= wr_en_ff ? fill_ff : fill_ff - 1'b1;
        rd_valid_out <= 1'b0;
      end else begin
        if (wr_en_ff) begin
          fill_ff <= fill_ff + 1'b1;
        end
        if (!rd_valid_out && !rd_pend_ff && fill_ff != 0) begin
          rd_pend_ff <= 1'b1;
        end
        if (rd_pend_ff) begin
          rd_valid_out <= 1'b1;
          rd_data_out <= mem_q;
        end
      end
    end
  end

  // Flow and transmit pins float in reset, then drive; transmit idles high.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_out <= 1'b1;
      tx_oe_out <= 1'b0;
      rts_n_out <= 1'b1;
      rts_n_oe_out <= 1'b0;
    end else begin
      tx_out <= 1'b1;
      tx_oe_out <= 1'b1;
      rts_n_oe_out <= 1'b1;
      rts_n_out <= !strap_done_ff ||
        (fill_ff >= `BUF_DEPTH - `RTS_MARGIN);
    end
  end
endmodule

// ==== dv/host_tx_model.sv ====
// Host sender model driving the receiver's serial input.
// Assumes the flow input is the receiver's not-ready output.
`timescale 1ns/1ps
module host_tx_model (
  input wire clk_in,
  input wire rts_n_in,
  output logic line_out
);
  int bit_cyc = 868;
  initial line_out = 1'b1;
  // Waits while refused, then sends one whole frame; the line idles high.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    while (rts_n_in !== 1'b0) @(negedge clk_in);
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (bit_cyc) @(negedge clk_in);
    end
    line_out = 1'b1;
  endtask
endmodule

// ==== dv/serial_props.sv ====
// Port checker for the command serial receiver.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
module serial_props (
  // Clock and reset.
  input wire clk_in,
  input wire nrst_in,
  // Serial pins.
  input wire rx_in,
  input wire tx_out,
  input wire tx_oe_out,
  input wire rts_n_out,
  input wire rts_n_oe_out,
  // Byte consumer side.
  input wire rd_take_in,
  input wire [7:0] rd_data_out,
  input wire rd_valid_out,
  input wire overrun_out
);
  // Nothing is judged while reset leaves the pins undriven.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  tx_idle_a: assert property (tx_out) else $error("tx not idle");
  tx_drive_a: assert property ($past(nrst_in) |-> tx_oe_out)
    else $error("tx undriven");
  rts_drive_a: assert property ($past(nrst_in) |-> rts_n_oe_out)
    else $error("rts undriven");
  rts_start_a: assert property ($rose(rts_n_oe_out) |-> rts_n_out)
    else $error("rts low at start");
  take_drop_a: assert property (rd_take_in && rd_valid_out
    |=> !rd_valid_out [*2]) else $error("valid after take");
  head_hold_a: assert property (
    rd_valid_out && !rd_take_in && !overrun_out |=>
    overrun_out || rd_valid_out && $stable(rd_data_out))
    else $error("head byte moved");
  ovr_pulse_a: assert property (overrun_out |=> !overrun_out)
    else $error("overrun too long");
  stop_high_a: assert property (
    $rose(rd_valid_out) && !$past(rd_take_in, 3) |-> rx_in)
    else $error("byte without stop");
endmodule
bind command_serial_receiver_flow serial_props serial_props_i (
  .clk_in(clk_in), .nrst_in(nrst_in), .rx_in(rx_in), .tx_out(tx_out),
  .tx_oe_out(tx_oe_out), .rts_n_out(rts_n_out),
  .rts_n_oe_out(rts_n_oe_out), .rd_take_in(rd_take_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .overrun_out(overrun_out));

// ==== dv/tb_command_serial_receiver_flow.sv ====
// Self-checking bench for the command serial receiver.
// Assumes the host model sends frames; inputs move on falling edges.
`timescale 1ns/1ps
module tb_command_serial_receiver_flow;
  logic clk_in = 1'b0, nrst_in = 1'b0, hi = 1'b1, lo = 1'b1, take = 1'b0;
  wire rx, tx, tx_oe, rts_n, rts_oe, valid, ovr;
  wire [7:0] data;
  int n_errors = 0, samples_checked = 0;
  // Device and the host on its serial side.
  command_serial_receiver_flow command_serial_receiver_flow_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .rx_in(rx), .tx_out(tx),
    .tx_oe_out(tx_oe), .rts_n_out(rts_n), .rts_n_oe_out(rts_oe),
    .rate_pick_hi_in(hi), .rate_pick_lo_in(lo), .rd_take_in(take),
    .rd_data_out(data), .rd_valid_out(valid), .overrun_out(ovr));
  host_tx_model host_tx_model_i (.clk_in(clk_in), .rts_n_in(rts_n),
    .line_out(rx));
  // Clock at 100 MHz.
  initial forever #5 clk_in = ~clk_in;
  // Compare and count.
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Reset with the given straps; pins must float while reset holds.
  task automatic rst(input logic h, input logic l);
    nrst_in = 1'b0;
    hi = h;
    lo = l;
    repeat (16) @(negedge clk_in);
    cmp({7'h00, tx_oe, rts_oe}, 9'h000);
    nrst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    cmp({7'h00, tx, rts_n}, 9'h002);
  endtask
  // Waits a bounded time for the head byte, checks it, then pops it.
  task automatic pop(input logic [7:0] b);
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    cmp({valid, data}, {1'b1, b});
    take = 1'b1;
    @(negedge clk_in);
    take = 1'b0;
  endtask
  task automatic t_frame;
    rst(1'b1, 1'b1);
    host_tx_model_i.send(8'hA5, 1'b1);
    pop(8'hA5);
    host_tx_model_i.send(8'h3C, 1'b1);
    host_tx_model_i.send(8'hC3, 1'b1);
    pop(8'h3C);
    pop(8'hC3);
    $display("frame test done");
  endtask
  // A low stop bit loses the byte but not the following one.
  task automatic t_badstop;
    host_tx_model_i.send(8'h5A, 1'b0);
    repeat (20) @(negedge clk_in);
    cmp({8'h00, valid}, 9'h000);
    host_tx_model_i.send(8'h81, 1'b1);
    pop(8'h81);
    $display("stop test done");
  endtask
  // Straps moved after reset must not change the rate in use.
  task automatic t_rate;
    host_tx_model_i.bit_cyc = 2604;
    rst(1'b1, 1'b0);
    hi = 1'b0;
    host_tx_model_i.send(8'h96, 1'b1);
    pop(8'h96);
    $display("rate test done");
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_frame;
    t_badstop;
    t_rate;
    print_verdict;
  end
  // Watchdog: the tests need about 70k cycles, so 95k means a hang.
  initial begin
    #950000;
    n_errors++;
    print_verdict;
  end
endmodule
